// File: fpe_map.svh
// Constants for the flash program/erase controller: access modes, timings, erased word, alignment mask.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH
`define FPE_CLK_PERIOD_PS 4000
`define FPE_MODE_READ_ONLY 2'h0
`define FPE_MODE_WRITE_EN 2'h1
`define FPE_MODE_ERASE_EN 2'h2
`define FPE_WORD_WRITE_TIME_NS 40
`define FPE_PAGE_ERASE_TIME_NS 400
`define FPE_FULL_ERASE_TIME_NS 800
`define FPE_ERASED_WORD 32'hffffffff
`define FPE_ALIGN_MASK 2'h3
`define FPE_ZERO_CYCLES 32'h0
`endif

// File: fpe_pkg.sv
// Types shared by the flash program/erase controller.
// Needs no constants header; the state encoding is defined here directly.
package fpe_pkg;
	typedef enum logic [2:0] {
		FPE_IDLE = 3'b000,
		FPE_PROGRAM = 3'b001,
		FPE_PAGE_ERASE = 3'b010,
		FPE_USER_ERASE = 3'b011,
		FPE_FULL_ERASE = 3'b100
	} fpe_state_type;
endpackage : fpe_pkg

// File: fpe_array.sv
// Flash array model: code pages plus the user configuration area in one word memory.
// Assumes the controller issues at most one word write or one erase per cycle.
`timescale 1ns/100ps
`include "fpe_map.svh"
module fpe_array #(
	parameter int ADDR_WIDTH = 8,
	parameter int PAGE_WORDS_LOG2 = 4,
	parameter int USER_WORDS = 16
) (
	input wire logic core_clk,
	input wire logic writeEn,
	input wire logic [ADDR_WIDTH-1:0] writeAddr,
	input wire logic [31:0] writeData,
	input wire logic pageEraseEn,
	input wire logic userEraseEn,
	input wire logic fullEraseEn,
	input wire logic [ADDR_WIDTH-1:0] readAddr,
	output logic [31:0] readData,
	output logic [31:0] userWord0
);
	localparam int DEPTH = 1 << ADDR_WIDTH;
	localparam int USER_BASE = DEPTH - USER_WORDS;
	logic [31:0] mem [DEPTH];
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (fullEraseEn) begin
				mem[i] <= `FPE_ERASED_WORD;
			end else if (userEraseEn && i >= USER_BASE) begin
				mem[i] <= `FPE_ERASED_WORD;
			end else if (pageEraseEn && i >= USER_BASE) begin
				mem[i] <= mem[i];
			end else if (pageEraseEn && (i >> PAGE_WORDS_LOG2) == (writeAddr >> PAGE_WORDS_LOG2)) begin
				mem[i] <= `FPE_ERASED_WORD;
			end else if (writeEn && i == writeAddr) begin
				// Only 1 to 0 transitions; a 1 never returns without erase
				mem[i] <= mem[i] & writeData;
			end
		end
		readData <= mem[readAddr];
		userWord0 <= mem[USER_BASE];
	end

	a_clear_only: assert property (@(posedge core_clk)
		(writeEn && !pageEraseEn && !userEraseEn && !fullEraseEn)
		|=> (mem[$past(writeAddr)] & ~$past(mem[writeAddr])) == 32'h0)
		else $error("programming turned a cleared bit back to one");
	a_page_ones: assert property (@(posedge core_clk)
		(pageEraseEn && !fullEraseEn && writeAddr < USER_BASE)
		|=> mem[$past(writeAddr)] == `FPE_ERASED_WORD)
		else $error("page erase left a bit cleared");
endmodule : fpe_array

// File: flash_program_erase_controller.sv
// Overview of operation
// - The controller alone programs and erases flash and the user area.
// - In write mode only full 32-bit words at aligned addresses program.
// - Programming only clears bits; only erase returns bits to one.
// - Byte or half-word aligned program access raises a hard fault, not performed.
// - Processor stalls for the word write time while a word programs.
// - In erase mode a page erase sets one page to ones, page erase time.
// - During page erase the processor stalls only on flash fetches.
// - User area programs like flash; new configuration applies after next reset.
// - Processor stalls for the word write time while user area programs.
// - In erase mode user-area erase sets it all to ones, page erase time.
// - Full erase clears flash and user area, full erase time.
// - During user or full erase the processor stalls only on flash execution.
// - Ready reads 0 while busy and 1 when idle.
// - Access mode encodes read-only 0, write 1, erase 2.
// File holds the controller top with a word-addressed flash array underneath.
// Assumes requests are single-cycle pulses from the processor bus decoder.
// Operation times are nanosecond parameters, rounded up to whole clock cycles.
`timescale 1ns/100ps
`include "fpe_map.svh"
module flash_program_erase_controller #(
	parameter int ADDR_WIDTH = 8,
	parameter int PAGE_WORDS_LOG2 = 4,
	parameter int USER_WORDS = 16,
	parameter int WORD_WRITE_TIME_NS = `FPE_WORD_WRITE_TIME_NS,
	parameter int PAGE_ERASE_TIME_NS = `FPE_PAGE_ERASE_TIME_NS,
	parameter int FULL_ERASE_TIME_NS = `FPE_FULL_ERASE_TIME_NS
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [1:0] accessMode,
	input wire logic programRequest,
	input wire logic [ADDR_WIDTH+1:0] programByteAddr,
	input wire logic [31:0] programData,
	input wire logic page_erase_request,
	input wire logic [ADDR_WIDTH+1:0] pageEraseByteAddr,
	input wire logic user_area_erase_request,
	input wire logic full_erase_request,
	input wire logic cpuFetchFromFlash,
	input wire logic [ADDR_WIDTH-1:0] readWordAddr,
	output logic [31:0] readData,
	output logic ready,
	output logic cpuStall,
	output logic hardFault,
	output logic [31:0] userConfigWord
);
	localparam int WRITE_CYCLES_RAW = (WORD_WRITE_TIME_NS * 1000 + `FPE_CLK_PERIOD_PS - 1)
		/ `FPE_CLK_PERIOD_PS;
	localparam int PAGE_CYCLES_RAW = (PAGE_ERASE_TIME_NS * 1000 + `FPE_CLK_PERIOD_PS - 1)
		/ `FPE_CLK_PERIOD_PS;
	localparam int FULL_CYCLES_RAW = (FULL_ERASE_TIME_NS * 1000 + `FPE_CLK_PERIOD_PS - 1)
		/ `FPE_CLK_PERIOD_PS;
	localparam logic [31:0] WRITE_CYCLES = 32'(WRITE_CYCLES_RAW < 1 ? 1 : WRITE_CYCLES_RAW);
	localparam logic [31:0] PAGE_CYCLES = 32'(PAGE_CYCLES_RAW < 1 ? 1 : PAGE_CYCLES_RAW);
	localparam logic [31:0] FULL_CYCLES = 32'(FULL_CYCLES_RAW < 1 ? 1 : FULL_CYCLES_RAW);

	fpe_pkg::fpe_state_type state_reg, state_next;
	logic [31:0] count_reg, count_next;
	logic [ADDR_WIDTH-1:0] addr_reg, addr_next;
	logic [31:0] data_reg, data_next;
	logic hardFault_reg, hardFault_next;
	logic configLoaded_reg, configLoaded_next;
	logic [31:0] userConfig_reg, userConfig_next;
	logic arrWriteEn, arrPageErase, arrUserErase, arrFullErase, opDone;
	logic [31:0] arrUserWord0;
	logic writeMode, eraseMode, misaligned;

	assign writeMode = accessMode == `FPE_MODE_WRITE_EN;
	assign eraseMode = accessMode == `FPE_MODE_ERASE_EN;
	assign misaligned = (programByteAddr[1:0] & `FPE_ALIGN_MASK) != 2'h0;
	assign opDone = count_reg == 32'h1;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		hardFault_next = 1'b0;
		unique case (state_reg)
			fpe_pkg::FPE_IDLE: begin
				// Requests only honoured from idle; one operation at a time
				if (programRequest && writeMode) begin
					if (misaligned) begin
						hardFault_next = 1'b1;
					end else begin
						state_next = fpe_pkg::FPE_PROGRAM;
						count_next = WRITE_CYCLES;
						addr_next = programByteAddr[ADDR_WIDTH+1:2];
						data_next = programData;
					end
				end else if (full_erase_request && eraseMode) begin
					state_next = fpe_pkg::FPE_FULL_ERASE;
					count_next = FULL_CYCLES;
				end else if (user_area_erase_request && eraseMode) begin
					state_next = fpe_pkg::FPE_USER_ERASE;
					count_next = PAGE_CYCLES;
				end else if (page_erase_request && eraseMode) begin
					state_next = fpe_pkg::FPE_PAGE_ERASE;
					count_next = PAGE_CYCLES;
					addr_next = pageEraseByteAddr[ADDR_WIDTH+1:2];
				end
			end
			fpe_pkg::FPE_PROGRAM, fpe_pkg::FPE_PAGE_ERASE,
			fpe_pkg::FPE_USER_ERASE, fpe_pkg::FPE_FULL_ERASE: begin
				count_next = count_reg - 32'h1;
				if (opDone) begin
					state_next = fpe_pkg::FPE_IDLE;
				end
			end
			default: begin
				state_next = fpe_pkg::FPE_IDLE;
				count_next = `FPE_ZERO_CYCLES;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= fpe_pkg::FPE_IDLE;
			count_reg <= `FPE_ZERO_CYCLES;
			addr_reg <= '0;
			data_reg <= `FPE_ERASED_WORD;
			hardFault_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			hardFault_reg <= hardFault_next;
		end
	end

	// Array is committed on the last cycle so the timing matches a real cell
	assign arrWriteEn = state_reg == fpe_pkg::FPE_PROGRAM && opDone;
	assign arrPageErase = state_reg == fpe_pkg::FPE_PAGE_ERASE && opDone;
	assign arrUserErase = state_reg == fpe_pkg::FPE_USER_ERASE && opDone;
	assign arrFullErase = state_reg == fpe_pkg::FPE_FULL_ERASE && opDone;

	fpe_array #(
		.ADDR_WIDTH(ADDR_WIDTH),
		.PAGE_WORDS_LOG2(PAGE_WORDS_LOG2),
		.USER_WORDS(USER_WORDS)
	) u_array (
		.core_clk(core_clk),
		.writeEn(arrWriteEn),
		.writeAddr(addr_reg),
		.writeData(data_reg),
		.pageEraseEn(arrPageErase),
		.userEraseEn(arrUserErase),
		.fullEraseEn(arrFullErase),
		.readAddr(readWordAddr),
		.readData(readData),
		.userWord0(arrUserWord0)
	);

	// Configuration snapshot taken once after reset release; later writes wait for reset
	always_comb begin
		configLoaded_next = 1'b1;
		userConfig_next = configLoaded_reg ? userConfig_reg : arrUserWord0;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			configLoaded_reg <= 1'b0;
			userConfig_reg <= `FPE_ERASED_WORD;
		end else begin
			configLoaded_reg <= configLoaded_next;
			userConfig_reg <= userConfig_next;
		end
	end

	// Checking aid: busy and stall cycles counted apart from the sequencer counter
	fpe_pkg::fpe_state_type lastOp_reg, lastOp_next;
	logic [31:0] busyLen_reg, busyLen_next;
	logic [31:0] stallLen_reg, stallLen_next;

	always_comb begin
		lastOp_next = lastOp_reg;
		busyLen_next = busyLen_reg;
		stallLen_next = stallLen_reg;
		if (state_reg != fpe_pkg::FPE_IDLE) begin
			lastOp_next = state_reg;
			busyLen_next = busyLen_reg + 32'h1;
			stallLen_next = stallLen_reg + {31'h0, cpuStall};
		end else if (state_next != fpe_pkg::FPE_IDLE) begin
			// Cleared as an operation is taken so the totals stand until the next one
			busyLen_next = `FPE_ZERO_CYCLES;
			stallLen_next = `FPE_ZERO_CYCLES;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			lastOp_reg <= fpe_pkg::FPE_IDLE;
			busyLen_reg <= `FPE_ZERO_CYCLES;
			stallLen_reg <= `FPE_ZERO_CYCLES;
		end else begin
			lastOp_reg <= lastOp_next;
			busyLen_reg <= busyLen_next;
			stallLen_reg <= stallLen_next;
		end
	end

	assign userConfigWord = userConfig_reg;
	assign hardFault = hardFault_reg;
	assign ready = state_reg == fpe_pkg::FPE_IDLE;
	// Program stalls always; erases stall only a flash fetch
	assign cpuStall = state_reg == fpe_pkg::FPE_PROGRAM
		|| (state_reg != fpe_pkg::FPE_IDLE && cpuFetchFromFlash);

	a_ready_busy: assert property (@(posedge core_clk) disable iff (reset)
		ready == (count_reg == `FPE_ZERO_CYCLES))
		else $error("ready does not match idle state");
	a_program_stall: assert property (@(posedge core_clk) disable iff (reset)
		(ready && programRequest && writeMode && !misaligned)
		|=> cpuStall [*1] ##0 !ready)
		else $error("program did not stall processor");
	a_misalign_fault: assert property (@(posedge core_clk) disable iff (reset)
		(ready && programRequest && writeMode && misaligned) |=> hardFault && ready)
		else $error("misaligned program did not fault");
	a_mode_ignore: assert property (@(posedge core_clk) disable iff (reset)
		(ready && accessMode == `FPE_MODE_READ_ONLY) |=> ready)
		else $error("request taken in read-only mode");
	a_erase_nostall: assert property (@(posedge core_clk) disable iff (reset)
		(state_reg == fpe_pkg::FPE_PAGE_ERASE && !cpuFetchFromFlash) |-> !cpuStall)
		else $error("erase stalled non-flash execution");
	a_write_length: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state_reg == fpe_pkg::FPE_PROGRAM) |-> count_reg == WRITE_CYCLES)
		else $error("word write time wrong");
	a_page_length: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state_reg == fpe_pkg::FPE_PAGE_ERASE) |-> count_reg == PAGE_CYCLES)
		else $error("page erase time wrong");
	a_full_length: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state_reg == fpe_pkg::FPE_FULL_ERASE) |-> count_reg == FULL_CYCLES)
		else $error("full erase time wrong");
	a_config_hold: assert property (@(posedge core_clk) disable iff (reset)
		configLoaded_reg |=> $stable(userConfigWord))
		else $error("configuration changed without reset");

	// Stalls, erase acceptance and refused requests
	a_user_nostall: assert property (@(posedge core_clk) disable iff (reset)
		((state_reg == fpe_pkg::FPE_USER_ERASE || state_reg == fpe_pkg::FPE_FULL_ERASE)
		&& !cpuFetchFromFlash) |-> !cpuStall)
		else $error("user or full erase stalled non-flash execution");
	a_fetch_stall: assert property (@(posedge core_clk) disable iff (reset)
		(!ready && cpuFetchFromFlash)
		|-> cpuStall)
		else $error("flash fetch not stalled during operation");
	a_stall_cause: assert property (@(posedge core_clk) disable iff (reset)
		(cpuStall && !cpuFetchFromFlash)
		|-> state_reg == fpe_pkg::FPE_PROGRAM)
		else $error("processor stalled outside programming");
	a_erase_start: assert property (@(posedge core_clk) disable iff (reset)
		(ready && eraseMode
		&& (page_erase_request || user_area_erase_request || full_erase_request))
		|=> !ready)
		else $error("erase request in erase mode not taken");
	a_erase_gated: assert property (@(posedge core_clk) disable iff (reset)
		(ready && !eraseMode && !(programRequest && writeMode && !misaligned))
		|=> ready)
		else $error("erase taken outside erase mode");
	a_aligned_only: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state_reg == fpe_pkg::FPE_PROGRAM)
		|-> $past(programByteAddr[1:0]) == 2'h0)
		else $error("program started at an unaligned address");
	a_fault_cause: assert property (@(posedge core_clk) disable iff (reset)
		hardFault
		|-> $past(ready && programRequest && writeMode && misaligned))
		else $error("hard fault without a misaligned program");
	a_fault_ready: assert property (@(posedge core_clk) disable iff (reset)
		hardFault |-> ready)
		else $error("misaligned program was performed");

	// Operation lengths
	a_busy_count: assert property (@(posedge core_clk) disable iff (reset)
		(!ready && !opDone)
		|=> !ready && count_reg == $past(count_reg) - 32'h1)
		else $error("busy operation restarted or stopped early");
	a_done_idle: assert property (@(posedge core_clk) disable iff (reset)
		(!ready && opDone) |=> ready)
		else $error("ready not restored after the last cycle");
	a_write_busy: assert property (@(posedge core_clk) disable iff (reset)
		($rose(ready) && lastOp_reg == fpe_pkg::FPE_PROGRAM)
		|-> busyLen_reg == WRITE_CYCLES)
		else $error("word write busy time wrong");
	a_write_stall: assert property (@(posedge core_clk) disable iff (reset)
		($rose(ready) && lastOp_reg == fpe_pkg::FPE_PROGRAM)
		|-> stallLen_reg == WRITE_CYCLES)
		else $error("processor not stalled for the whole word write");
	a_page_busy: assert property (@(posedge core_clk) disable iff (reset)
		($rose(ready) && (lastOp_reg == fpe_pkg::FPE_PAGE_ERASE
		|| lastOp_reg == fpe_pkg::FPE_USER_ERASE))
		|-> busyLen_reg == PAGE_CYCLES)
		else $error("page or user-area erase busy time wrong");
	a_full_busy: assert property (@(posedge core_clk) disable iff (reset)
		($rose(ready) && lastOp_reg == fpe_pkg::FPE_FULL_ERASE)
		|-> busyLen_reg == FULL_CYCLES)
		else $error("full erase busy time wrong");
endmodule : flash_program_erase_controller

// File: fpe_cpu_model.sv
// Processor-side model: issues program and erase requests and reads words back.
// Assumes the controller takes single-cycle request pulses on core_clk.
`timescale 1ns/100ps
module fpe_cpu_model (
	input wire logic core_clk,
	input wire logic ready,
	input wire logic cpuStall,
	input wire logic [31:0] readData,
	output logic [1:0] accessMode,
	output logic programRequest,
	output logic [9:0] programByteAddr,
	output logic [31:0] programData,
	output logic page_erase_request,
	output logic [9:0] pageEraseByteAddr,
	output logic user_area_erase_request,
	output logic full_erase_request,
	output logic cpuFetchFromFlash,
	output logic [7:0] readWordAddr
);
	initial begin
		accessMode = 2'h0;
		{programRequest, page_erase_request, user_area_erase_request, full_erase_request} = 4'h0;
		{programByteAddr, pageEraseByteAddr, programData, readWordAddr} = 60'h0;
		cpuFetchFromFlash = 1'b0;
	end
	// One mode field, so write and erase can never be on together
	task automatic setMode(input logic [1:0] m, input logic fetch);
		accessMode = m;
		cpuFetchFromFlash = fetch;
		@(posedge core_clk);
		#1;
	endtask : setMode
	// Kinds: 0 program, 1 page erase, 2 user-area erase, 3 full erase
	task automatic runOp(input int kind, input logic [9:0] addr, input logic [31:0] data,
		output int busy, output int stalls);
		busy = 0;
		stalls = 0;
		// Idle edge first so no strobe is lowered and raised in one time step
		@(posedge core_clk);
		#1;
		programByteAddr = addr;
		pageEraseByteAddr = addr;
		programData = data;
		programRequest = (kind == 0);
		page_erase_request = (kind == 1);
		user_area_erase_request = (kind == 2);
		full_erase_request = (kind == 3);
		@(posedge core_clk);
		#1;
		{programRequest, page_erase_request, user_area_erase_request, full_erase_request} = 4'h0;
		while (ready !== 1'b1 && busy < 1000) begin
			busy++;
			stalls += cpuStall;
			@(posedge core_clk);
			#1;
		end
	endtask : runOp
	task automatic readWord(input logic [7:0] a, output logic [31:0] d);
		readWordAddr = a;
		@(posedge core_clk);
		#1;
		d = readData;
	endtask : readWord
endmodule : fpe_cpu_model

// File: flash_program_erase_controller_bench.sv
// Self-checking bench for the flash program/erase controller.
// Assumes default geometry: 256 words, 16-word pages, user area at word 240.
`timescale 1ns/100ps
`include "fpe_map.svh"
module flash_program_erase_controller_bench;
	localparam int TW = `FPE_WORD_WRITE_TIME_NS / 4;
	localparam int TP = `FPE_PAGE_ERASE_TIME_NS / 4;
	localparam int TF = `FPE_FULL_ERASE_TIME_NS / 4;
	logic core_clk, reset, programRequest, page_erase_request, user_area_erase_request;
	logic full_erase_request, cpuFetchFromFlash, ready, cpuStall, hardFault;
	logic [1:0] accessMode;
	logic [9:0] programByteAddr, pageEraseByteAddr;
	logic [7:0] readWordAddr;
	logic [31:0] programData, readData, userConfigWord, rd;
	int fails = 0, nTests = 0, busy, stalls;
	flash_program_erase_controller flash_program_erase_controller_i (.core_clk(core_clk),
		.reset(reset), .accessMode(accessMode), .programRequest(programRequest),
		.programByteAddr(programByteAddr), .programData(programData),
		.page_erase_request(page_erase_request), .pageEraseByteAddr(pageEraseByteAddr),
		.user_area_erase_request(user_area_erase_request),
		.full_erase_request(full_erase_request), .cpuFetchFromFlash(cpuFetchFromFlash),
		.readWordAddr(readWordAddr), .readData(readData), .ready(ready),
		.cpuStall(cpuStall), .hardFault(hardFault), .userConfigWord(userConfigWord));
	fpe_cpu_model fpe_cpu_model_i (.core_clk(core_clk), .ready(ready), .cpuStall(cpuStall),
		.readData(readData), .accessMode(accessMode), .programRequest(programRequest),
		.programByteAddr(programByteAddr), .programData(programData),
		.page_erase_request(page_erase_request), .pageEraseByteAddr(pageEraseByteAddr),
		.user_area_erase_request(user_area_erase_request),
		.full_erase_request(full_erase_request), .cpuFetchFromFlash(cpuFetchFromFlash),
		.readWordAddr(readWordAddr));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic word(input logic [7:0] a, input logic [31:0] exp);
		fpe_cpu_model_i.readWord(a, rd);
		check("array word", exp, rd);
	endtask : word
	task automatic opCheck(input int kind, input logic [9:0] a, input logic [31:0] d,
		input int expBusy, input int expStalls);
		fpe_cpu_model_i.runOp(kind, a, d, busy, stalls);
		check("busy cycles", expBusy, busy);
		check("stall cycles", expStalls, stalls);
	endtask : opCheck
	task automatic testReset;
		check("ready", 32'h1, ready);
		check("hardFault", 32'h0, hardFault);
		check("cpuStall", 32'h0, cpuStall);
	endtask : testReset
	task automatic testFullErase;
		fpe_cpu_model_i.setMode(`FPE_MODE_ERASE_EN, 1'b1);
		opCheck(3, 10'h000, 32'h0, TF, TF);
		word(8'h03, `FPE_ERASED_WORD);
		word(8'hf0, `FPE_ERASED_WORD);
	endtask : testFullErase
	task automatic testProgram;
		fpe_cpu_model_i.setMode(`FPE_MODE_WRITE_EN, 1'b0);
		opCheck(0, 10'h00c, 32'h12345678, TW, TW);
		word(8'h03, 32'h12345678);
		opCheck(0, 10'h00c, 32'hffff00ff, TW, TW);
		word(8'h03, 32'h12340078);
		for (int i = 1; i < 4; i++) begin
			fpe_cpu_model_i.runOp(0, 10'h00c + i[9:0], 32'h0, busy, stalls);
			rd = {31'h0, hardFault};
			@(posedge core_clk);
			#1;
			rd += {31'h0, hardFault};
			check("hardFault pulses", 32'h1, rd);
			check("misaligned busy", 32'h0, busy);
		end
		word(8'h03, 32'h12340078);
		opCheck(0, 10'h040, 32'h0f0f0f0f, TW, TW);
	endtask : testProgram
	task automatic testWrongMode;
		fpe_cpu_model_i.setMode(`FPE_MODE_READ_ONLY, 1'b0);
		opCheck(0, 10'h00c, 32'h0, 0, 0);
		fpe_cpu_model_i.setMode(`FPE_MODE_WRITE_EN, 1'b0);
		opCheck(1, 10'h000, 32'h0, 0, 0);
		opCheck(3, 10'h000, 32'h0, 0, 0);
		fpe_cpu_model_i.setMode(2'h3, 1'b0);
		opCheck(2, 10'h000, 32'h0, 0, 0);
		word(8'h03, 32'h12340078);
	endtask : testWrongMode
	task automatic testPageErase;
		fpe_cpu_model_i.setMode(`FPE_MODE_ERASE_EN, 1'b1);
		opCheck(1, 10'h008, 32'h0, TP, TP);
		word(8'h03, `FPE_ERASED_WORD);
		word(8'h10, 32'h0f0f0f0f);
	endtask : testPageErase
	task automatic pulseReset;
		reset = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 reset = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : pulseReset
	task automatic testUserArea;
		// Snapshot taken at start-up saw an unwritten array; reload it from the erased area
		pulseReset();
		testReset();
		check("config erased", `FPE_ERASED_WORD, userConfigWord);
		fpe_cpu_model_i.setMode(`FPE_MODE_WRITE_EN, 1'b0);
		opCheck(0, 10'h3c0, 32'ha5a5a5a5, TW, TW);
		check("config before reset", `FPE_ERASED_WORD, userConfigWord);
		pulseReset();
		check("config after reset", 32'ha5a5a5a5, userConfigWord);
		fpe_cpu_model_i.setMode(`FPE_MODE_ERASE_EN, 1'b0);
		opCheck(2, 10'h000, 32'h0, TP, 0);
		word(8'hf0, `FPE_ERASED_WORD);
		check("config after erase", 32'ha5a5a5a5, userConfigWord);
	endtask : testUserArea
	task automatic end_sim;
		if (fails == 0 && nTests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		reset = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 reset = 1'b0;
		testReset();
		testFullErase();
		testProgram();
		testWrongMode();
		testPageErase();
		testUserArea();
		end_sim();
	end
	// About 500 cycles of work expected; ten times that is a hang
	initial begin
		#20000;
		fails++;
		end_sim();
	end
endmodule : flash_program_erase_controller_bench
